// ==== verilog/tsf_pkg.sv ====
// constants, field layout and types of the timer and frame-checking serial block
//
// Behaviour
// - timer counts only while run bit set
// - source select zero counts internal clock
// - source select one counts pin falling edges
// - enabled trigger edge captures/reloads outside baud mode, sets event flag
// - control register resets zero, bit addressable
// - three full-duplex async modes, separate baud rates
// - stop check only in asynchronous modes
// - stop check only while check enabled
// - invalid stop bit sets frame error flag
// - frame error cleared only by software/reset
// - good frames leave frame error unchanged
// - checking moves receive done to stop bit
package tsf_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_COUNT  = 8'h00;
  localparam logic [7:0] ADDR_RELOAD = 8'h04;
  localparam logic [7:0] ADDR_SCTL   = 8'h08;
  localparam logic [7:0] ADDR_SDATA  = 8'h0C;
  localparam logic [7:0] ADDR_PCTL   = 8'h10;
  localparam logic [7:0] ADDR_TCTL   = 8'hC8;
  localparam logic [7:0] ADDR_TBIT   = 8'hCC;

  // ==========================================================
  // timer_three_control fields
  localparam int TC_TF   = 7;
  localparam int TC_EXF  = 6;
  localparam int TC_RCLK = 5;
  localparam int TC_TX_BAUD_SOURCE_SELECT = 4;
  localparam int TC_EXEN = 3;
  localparam int TC_TR   = 2;
  localparam int TC_CT   = 1;
  localparam int TC_CP   = 0;
  // single-bit access: index in [2:0], value in [3]
  localparam int TB_VAL  = 3;

  // ==========================================================
  // serial control fields
  localparam int SC_RXDONE = 0;
  localparam int SC_TXDONE = 1;
  localparam int SC_RB8    = 2;
  localparam int SC_TB8    = 3;
  localparam int SC_RXEN   = 4;
  localparam int SC_MODE   = 6;
  localparam int SC_FE     = 8;
  localparam int SC_TXBUSY = 9;
  localparam int SC_RXAVL  = 10;
  localparam int PC_FCE    = 0;
  localparam int SD_VALID  = 15;

  // ==========================================================
  // reset values, encodings, timing
  localparam logic [7:0]  TCTL_RST  = 8'h00;
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [15:0] CNT_TOP   = 16'hFFFF;
  localparam logic [1:0]  MODE_SYNC = 2'h0;
  localparam logic [1:0]  MODE_A8   = 2'h1;
  localparam logic [3:0]  OS_MID    = 4'h7;
  localparam logic [3:0]  OS_END    = 4'hF;
  localparam logic [3:0]  TX_LEN8   = 4'hA;
  localparam logic [3:0]  TX_LEN9   = 4'hB;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} tsf_rx_state_t;

endpackage

// ==== verilog/tsf_fifo.sv ====
`timescale 1ns/1ps
// receive word buffer with valid/ready on both sides
module tsf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
)(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      used;
  logic             push;
  logic             pop;

  assign in_ready  = (used != (AW+1)'(DEPTH));
  assign out_valid = (used != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // depth must be a power of two so the pointers wrap by themselves
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      used   <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      used   <= used + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== verilog/tsf_top.sv ====
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// timer with capture/reload and baud output, plus frame-checking serial port
module tsf_top
  import tsf_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // timer pins
  input  wire logic        count_input_pin,
  input  wire logic        external_trigger_pin,
  input  wire logic        other_timer_overflow,
  output logic             timer_overflow_pulse,
  // serial line
  input  wire logic        rx_pin,
  output logic             tx_pin
);

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_COUNT) || (a == ADDR_RELOAD) || (a == ADDR_SCTL) || (a == ADDR_SDATA)
          || (a == ADDR_PCTL) || (a == ADDR_TCTL) || (a == ADDR_TBIT);
  endfunction

  // ==========================================================
  // axi write channel: address and data taken in either order
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic        w_lane0;
  logic        aw_fire;
  logic        w_fire;
  logic        wr_fire;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire  = s_axi_wvalid && s_axi_wready;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
    end else begin
      aw_held       <= aw_fire || (aw_held && !wr_fire);
      w_held        <= w_fire || (w_held && !wr_fire);
      s_axi_awready <= !(aw_fire || (aw_held && !wr_fire));
      s_axi_wready  <= !(w_fire || (w_held && !wr_fire));
      if (aw_fire) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_data  <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register strobes; byte lane 0 must be enabled for any effect
  logic sw_count;
  logic sw_reload;
  logic sw_sctl;
  logic sw_sdata;
  logic sw_pctl;
  logic sw_tctl;
  logic sw_tbit;
  assign sw_count  = wr_fire && w_lane0 && (aw_addr == ADDR_COUNT);
  assign sw_reload = wr_fire && w_lane0 && (aw_addr == ADDR_RELOAD);
  assign sw_sctl   = wr_fire && w_lane0 && (aw_addr == ADDR_SCTL);
  assign sw_sdata  = wr_fire && w_lane0 && (aw_addr == ADDR_SDATA);
  assign sw_pctl   = wr_fire && w_lane0 && (aw_addr == ADDR_PCTL);
  assign sw_tctl   = wr_fire && w_lane0 && (aw_addr == ADDR_TCTL);
  assign sw_tbit   = wr_fire && w_lane0 && (aw_addr == ADDR_TBIT);

  // ==========================================================
  // timer
  logic [7:0]  tctl;
  logic [7:0]  next_tctl;
  logic [15:0] count;
  logic [15:0] reload;
  logic        cnt_pin_q;
  logic        trig_pin_q;
  logic        tick;
  logic        trig;
  logic        ovf;
  logic        baud_mode;

  always_comb begin
    next_tctl = tctl;
    if (sw_tctl) begin
      next_tctl = w_data[7:0];
    end
    if (sw_tbit) begin
      next_tctl[w_data[2:0]] = w_data[TB_VAL];
    end
  end

  assign tick = tctl[TC_TR] && (tctl[TC_CT] ? (cnt_pin_q && !count_input_pin) : 1'b1);
  assign trig = tctl[TC_EXEN] && trig_pin_q && !external_trigger_pin;
  assign ovf  = tick && (count == CNT_TOP);
  assign baud_mode = tctl[TC_RCLK] || tctl[TC_TX_BAUD_SOURCE_SELECT];

  // flags: a hardware set in the same cycle as a software clear wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tctl <= TCTL_RST;
    end else begin
      tctl <= next_tctl;
      if (ovf && !baud_mode) begin
        tctl[TC_TF] <= 1'b1;
      end
      if (trig) begin
        tctl[TC_EXF] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count                <= CNT_RST;
      reload               <= CNT_RST;
      cnt_pin_q            <= 1'b1;
      trig_pin_q           <= 1'b1;
      timer_overflow_pulse <= 1'b0;
    end else begin
      cnt_pin_q            <= count_input_pin;
      trig_pin_q           <= external_trigger_pin;
      timer_overflow_pulse <= ovf;
      if (sw_count) begin
        count <= w_data[15:0];
      end else if (ovf && (baud_mode || !tctl[TC_CP])) begin
        count <= reload;
      end else if (trig && !baud_mode && !tctl[TC_CP]) begin
        count <= reload;
      end else if (tick) begin
        count <= count + 16'h0001;
      end
      if (sw_reload) begin
        reload <= w_data[15:0];
      end else if (trig && !baud_mode && tctl[TC_CP]) begin
        reload <= count;
      end
    end
  end

  // baud ticks: each direction picks its own source so rates may differ
  logic rx_tick;
  logic tx_tick;
  assign rx_tick = tctl[TC_RCLK] ? ovf : other_timer_overflow;
  assign tx_tick = tctl[TC_TX_BAUD_SOURCE_SELECT] ? ovf : other_timer_overflow;

  // ==========================================================
  // serial control state
  logic [1:0] mode;
  logic       rx_en;
  logic       tx_b8;
  logic       rx_b8;
  logic       tx_done;
  logic       receive_done_flag;
  logic       frame_error_flag;
  logic       frame_check_enable;
  logic       check_on;
  assign check_on = frame_check_enable && (mode != MODE_SYNC);

  // ==========================================================
  // receiver
  tsf_rx_state_t rx_state;
  logic [3:0]    rx_os;
  logic [3:0]    rx_bit;
  logic [8:0]    rx_sh;
  logic [8:0]    rx_next_sh;
  logic [3:0]    rx_nbits;
  logic          last_data_evt;
  logic          stop_evt;
  logic          done_evt;
  logic          push_valid;
  logic [8:0]    push_data;
  logic          fifo_ready;
  logic          fifo_valid;
  logic [8:0]    fifo_data;
  logic          pop;
  logic          rx_pin_q;

  function automatic logic [8:0] frame_word(input logic [8:0] sh, input logic [1:0] m);
    frame_word = (m == MODE_A8) ? {1'b0, sh[8:1]} : sh;
  endfunction

  assign rx_nbits      = (mode == MODE_A8) ? 4'h8 : 4'h9;
  assign rx_next_sh    = {rx_pin, rx_sh[8:1]};
  assign last_data_evt = (rx_state == RX_DATA) && rx_tick && (rx_os == OS_END) && (rx_bit == rx_nbits - 4'h1);
  assign stop_evt      = (rx_state == RX_STOP) && rx_tick && (rx_os == OS_END);
  assign done_evt      = check_on ? stop_evt : last_data_evt;

  // a new frame is not started while the last word waits for buffer room
  // start needs a falling edge, so a stop bit still held low is never taken for a start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= RX_IDLE;
      rx_os    <= 4'h0;
      rx_bit   <= 4'h0;
      rx_sh    <= 9'h000;
      rx_pin_q <= 1'b1;
    end else begin
      rx_pin_q <= rx_pin;
      unique case (rx_state)
        RX_IDLE: begin
          rx_os  <= 4'h0;
          rx_bit <= 4'h0;
          if (rx_en && (mode != MODE_SYNC) && rx_pin_q && !rx_pin && !push_valid) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_os <= rx_os + 4'h1;
            if (rx_os == OS_MID) begin
              rx_os    <= 4'h0;
              rx_state <= rx_pin ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_os <= rx_os + 4'h1;
            if (rx_os == OS_END) begin
              rx_sh  <= rx_next_sh;
              rx_bit <= rx_bit + 4'h1;
              if (last_data_evt) begin
                rx_state <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            rx_os <= rx_os + 4'h1;
            if (stop_evt) begin
              rx_state <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      push_valid <= 1'b0;
      push_data  <= 9'h000;
    end else if (done_evt) begin
      push_valid <= 1'b1;
      push_data  <= check_on ? frame_word(rx_sh, mode) : frame_word(rx_next_sh, mode);
    end else if (fifo_ready) begin
      push_valid <= 1'b0;
    end
  end

  tsf_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push_valid),
    .in_ready  (fifo_ready),
    .in_data   (push_data),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  // ==========================================================
  // transmitter
  logic        tx_busy;
  logic [10:0] tx_sh;
  logic [3:0]  tx_left;
  logic [3:0]  tx_os;
  logic        tx_end;
  assign tx_end = tx_busy && tx_tick && (tx_os == OS_END) && (tx_left == 4'h1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      tx_sh   <= 11'h7FF;
      tx_left <= 4'h0;
      tx_os   <= 4'h0;
      tx_pin  <= 1'b1;
    end else begin
      tx_pin <= tx_busy ? tx_sh[0] : 1'b1;
      if (!tx_busy && sw_sdata && (mode != MODE_SYNC)) begin
        tx_busy <= 1'b1;
        tx_os   <= 4'h0;
        tx_sh   <= {1'b1, (mode == MODE_A8) ? 1'b1 : tx_b8, w_data[7:0], 1'b0};
        tx_left <= (mode == MODE_A8) ? TX_LEN8 : TX_LEN9;
      end else if (tx_busy && tx_tick) begin
        tx_os <= tx_os + 4'h1;
        if (tx_os == OS_END) begin
          tx_sh   <= {1'b1, tx_sh[10:1]};
          tx_left <= tx_left - 4'h1;
          tx_busy <= !tx_end;
        end
      end
    end
  end

  // serial flags: hardware sets win over software clears
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode               <= MODE_SYNC;
      rx_en              <= 1'b0;
      tx_b8              <= 1'b0;
      rx_b8              <= 1'b0;
      tx_done            <= 1'b0;
      receive_done_flag  <= 1'b0;
      frame_error_flag   <= 1'b0;
      frame_check_enable <= 1'b0;
    end else begin
      if (sw_pctl) begin
        frame_check_enable <= w_data[PC_FCE];
      end
      if (sw_sctl) begin
        mode              <= w_data[SC_MODE +: 2];
        rx_en             <= w_data[SC_RXEN];
        tx_b8             <= w_data[SC_TB8];
        tx_done           <= w_data[SC_TXDONE];
        receive_done_flag <= w_data[SC_RXDONE];
        frame_error_flag  <= w_data[SC_FE];
      end
      if (tx_end) begin
        tx_done <= 1'b1;
      end
      if (done_evt) begin
        receive_done_flag <= 1'b1;
        rx_b8             <= check_on ? rx_sh[8] : rx_next_sh[8];
      end
      if (stop_evt && check_on && !rx_pin) begin
        frame_error_flag <= 1'b1;
      end
    end
  end

  // ==========================================================
  // axi read channel; data is sampled when the address is taken
  logic ar_fire;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign pop     = ar_fire && (s_axi_araddr == ADDR_SDATA);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end else begin
      s_axi_arready <= !(ar_fire || (s_axi_rvalid && !s_axi_rready));
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
        unique case (s_axi_araddr)
          ADDR_COUNT:  s_axi_rdata <= {16'h0000, count};
          ADDR_RELOAD: s_axi_rdata <= {16'h0000, reload};
          ADDR_TCTL:   s_axi_rdata <= {24'h00_0000, tctl};
          ADDR_PCTL:   s_axi_rdata <= {31'h0000_0000, frame_check_enable};
          ADDR_SDATA:  s_axi_rdata <= {16'h0000, fifo_valid, 6'h00, fifo_data};
          ADDR_SCTL:   s_axi_rdata <= {21'h00_0000, fifo_valid, tx_busy, frame_error_flag, mode, 1'b0,
                                       rx_en, tx_b8, rx_b8, tx_done, receive_done_flag};
          default:     s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // checks
  sequence bad_stop;
    stop_evt && check_on && !rx_pin;
  endsequence
  sequence fe_not_cleared;
    frame_error_flag && !sw_sctl;
  endsequence

  AST_RUN_OFF_HOLD: assert property (!tctl[TC_TR] && !sw_count && !trig |=> $stable(count))
    else $error("count moved while stopped");
  AST_INTERNAL_INC: assert property (tctl[TC_TR] && !tctl[TC_CT] && count != CNT_TOP && !sw_count && !trig
    |=> count == $past(count) + 16'h0001)
    else $error("internal clock did not advance count");
  AST_PIN_NO_EDGE: assert property (tctl[TC_TR] && tctl[TC_CT] && !(cnt_pin_q && !count_input_pin)
    && !sw_count && !trig |=> $stable(count))
    else $error("count moved without a pin falling edge");
  AST_EXT_FLAG: assert property (trig |=> tctl[TC_EXF])
    else $error("trigger edge did not set event flag");
  AST_OVF_FLAG: assert property (ovf && !baud_mode |=> tctl[TC_TF] && timer_overflow_pulse)
    else $error("overflow flag not set");
  AST_BAUD_RELOAD: assert property (ovf && baud_mode && !sw_count |=> count == $past(reload))
    else $error("baud overflow did not reload");
  AST_CAPTURE: assert property (trig && tctl[TC_CP] && !baud_mode && !sw_reload
    |=> reload == $past(count) && tctl[TC_EXF])
    else $error("capture missed");
  AST_FE_SET: assert property (bad_stop |=> frame_error_flag ##1 frame_error_flag)
    else $error("bad stop bit not flagged");
  AST_FE_STICKY: assert property (fe_not_cleared |=> frame_error_flag)
    else $error("frame error cleared without software");
  AST_FE_ONLY_CHECKED: assert property ($rose(frame_error_flag) |-> $past(check_on) || $past(sw_sctl))
    else $error("frame error while checking off");
  AST_DONE_EARLY: assert property (!check_on && last_data_evt |=> receive_done_flag)
    else $error("receive done not at last data bit");

endmodule

// ==== sim/tsf_far_uart.sv ====
`timescale 1ns/1ps
// far-end serial transmitter driving the block's receive pin
module tsf_far_uart #(
  parameter int BIT_CLKS = 32
)(
  // clock
  input  wire logic clk,
  // line toward the block, idle high
  output logic      rx_line
);
  initial rx_line = 1'b1;
  // ==========================================================
  // one frame: start, eight bits lsb first, stop
  task automatic send(input logic [7:0] d, input logic good_stop);
    logic [9:0] f;
    f = {good_stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rx_line <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
    @(posedge clk);
    rx_line <= 1'b1;
    // idle gap so a low stop bit is never taken for the next start
    repeat (2 * BIT_CLKS) @(posedge clk);
  endtask
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ps
// self-checking bench for the timer and frame-checking serial block
module tb;
  import tsf_pkg::*;
  logic        clk, nrst, awv, wv, arv, cin, trg, otov, txlow;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd_d, v;
  logic [1:0]  rs, bs;
  wire         awr, wr_r, bv, arr, rvl, ovf, rxl, txp;
  wire  [1:0]  br, rr;
  wire  [31:0] rdt;
  int          n_errors, checks_done;
  localparam int FIFO_N = 16;
  tsf_top uut (.clk(clk), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rvl), .s_axi_rready(1'b1), .count_input_pin(cin),
    .external_trigger_pin(trg), .other_timer_overflow(otov), .timer_overflow_pulse(ovf), .rx_pin(rxl),
    .tx_pin(txp));
  tsf_far_uart far (.clk(clk), .rx_line(rxl));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // baud source: a one-cycle pulse every second cycle, so one bit is 32 clocks
  always @(posedge clk) otov <= ~otov;
  always @(negedge clk) if (txp === 1'b0) txlow = 1'b1;
  // ==========================================================
  // checking and closing
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic hang(input string what);
    n_errors++;
    $display("wrong value %s expected answer seen none", what);
    report_and_stop();
  endtask
  // ==========================================================
  // register bus master; handshakes are judged on values settled before the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    bh = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    for (int n = 0; !bh; n++) begin
      @(negedge clk);
      ah = awv & awr;
      wh = wv & wr_r;
      bh = bv;
      if (bv) bs = br;
      @(posedge clk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
      if (n > 200) hang("write answer");
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ah;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    for (int n = 0; ; n++) begin
      @(negedge clk);
      ah = arv & arr;
      if (rvl) begin
        rd_d = rdt;
        rs = rr;
        break;
      end
      @(posedge clk);
      if (ah) arv <= 1'b0;
      if (n > 200) hang("read answer");
    end
    @(posedge clk);
  endtask
  task automatic trig();
    @(posedge clk) trg <= 1'b0;
    repeat (4) @(posedge clk);
    trg <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic wait_ovf();
    for (int n = 0; ; n++) begin
      @(negedge clk);
      if (ovf === 1'b1) break;
      if (n > 300) hang("overflow pulse");
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(ADDR_TCTL);
    chk("control reset", 32'h0000_0000, rd_d);
    rd(8'hF0);
    chk("unmapped resp", {30'h0, RESP_ERR}, {30'h0, rs});
    wr(8'hF0, 32'h0);
    chk("unmapped bresp", {30'h0, RESP_ERR}, {30'h0, bs});
    wr(ADDR_PCTL, 32'h0);
    chk("write bresp", {30'h0, RESP_OK}, {30'h0, bs});
  endtask
  task automatic t_run();
    wr(ADDR_COUNT, 32'h0000_1234);
    repeat (10) @(posedge clk);
    rd(ADDR_COUNT);
    chk("count held", 32'h0000_1234, rd_d);
    wr(ADDR_TCTL, 32'h1 << TC_TR);
    rd(ADDR_COUNT);
    chk("count runs", 32'h1, {31'h0, rd_d > 32'h1234});
    wr(ADDR_TCTL, 32'h0);
    rd(ADDR_COUNT);
    v = rd_d;
    rd(ADDR_COUNT);
    chk("count stopped", v, rd_d);
  endtask
  task automatic t_pin();
    wr(ADDR_COUNT, 32'h0);
    wr(ADDR_TCTL, (32'h1 << TC_TR) | (32'h1 << TC_CT));
    repeat (5) begin
      @(posedge clk) cin <= 1'b0;
      repeat (3) @(posedge clk);
      cin <= 1'b1;
      repeat (3) @(posedge clk);
    end
    rd(ADDR_COUNT);
    chk("pin edges", 32'h5, rd_d);
  endtask
  task automatic t_trig();
    wr(ADDR_RELOAD, 32'h0000_00AB);
    wr(ADDR_COUNT, 32'h0000_0010);
    wr(ADDR_TCTL, 32'h1 << TC_EXEN);
    trig();
    rd(ADDR_COUNT);
    chk("reload", 32'h0000_00AB, rd_d);
    rd(ADDR_TCTL);
    chk("event flag", 32'h0000_0048, rd_d);
    wr(ADDR_TCTL, (32'h1 << TC_EXEN) | (32'h1 << TC_CP));
    wr(ADDR_COUNT, 32'h0000_0777);
    trig();
    rd(ADDR_RELOAD);
    chk("capture", 32'h0000_0777, rd_d);
    rd(ADDR_TCTL);
    chk("capture flag", 32'h0000_0049, rd_d);
    wr(ADDR_TBIT, 32'h0000_000A);
    wr(ADDR_TBIT, 32'h0000_0000);
    rd(ADDR_TCTL);
    chk("bit access", 32'h0000_004C, rd_d);
    wr(ADDR_TCTL, 32'h0);
  endtask
  task automatic t_ovf();
    wr(ADDR_COUNT, 32'h0000_FFE0);
    wr(ADDR_TCTL, 32'h1 << TC_TR);
    wait_ovf();
    rd(ADDR_TCTL);
    chk("overflow flag", 32'h0000_0084, rd_d);
    wr(ADDR_TCTL, 32'h0);
    wr(ADDR_COUNT, 32'h0000_FFE0);
    wr(ADDR_TCTL, (32'h1 << TC_TX_BAUD_SOURCE_SELECT) | (32'h1 << TC_TR));
    wait_ovf();
    rd(ADDR_TCTL);
    chk("baud no flag", 32'h0000_0014, rd_d);
    wr(ADDR_TCTL, 32'h0);
  endtask
  task automatic frame(input logic [7:0] d, input logic ok, input logic [31:0] e_sc);
    far.send(d, ok);
    rd(ADDR_SCTL);
    chk("status", e_sc, rd_d & 32'h0000_0101);
    rd(ADDR_SDATA);
    chk("word", {16'h0, 8'h80, d}, rd_d & 32'h0000_81FF);
  endtask
  task automatic t_serial();
    wr(ADDR_SCTL, 32'h0000_0050);
    wr(ADDR_PCTL, 32'h1);
    frame(8'h3C, 1'b0, 32'h0000_0101);
    frame(8'h5A, 1'b1, 32'h0000_0101);
    wr(ADDR_SCTL, 32'h0000_0050);
    rd(ADDR_SCTL);
    chk("cleared", 32'h0, rd_d & 32'h0000_0100);
    wr(ADDR_PCTL, 32'h0);
    frame(8'hA5, 1'b0, 32'h0000_0001);
    txlow = 1'b0;
    wr(ADDR_SDATA, 32'h0000_0055);
    frame(8'h33, 1'b1, 32'h0000_0001);
    chk("tx while rx", 32'h1, {31'h0, txlow});
    for (int i = 0; i < FIFO_N; i++) far.send(8'(i + 1), 1'b1);
    for (int i = 0; i < FIFO_N; i++) begin
      rd(ADDR_SDATA);
      chk("fifo word", {16'h0, 8'h80, 8'(i + 1)}, rd_d & 32'h0000_81FF);
    end
    rd(ADDR_SDATA);
    chk("fifo empty", 32'h0, rd_d & 32'h0000_8000);
  endtask
  initial begin
    n_errors = 0;
    checks_done = 0;
    nrst = 1'b0;
    {awv, wv, arv, otov, txlow} = '0;
    {cin, trg} = 2'b11;
    awa = 8'h0;
    ara = 8'h0;
    wd = 32'h0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_run();
    t_pin();
    t_trig();
    t_ovf();
    t_serial();
    report_and_stop();
  end
endmodule
